// file: src/afpa_framer.v
`timescale 1ns/1ps
`include "afpa_consts.vh"

// Function
// - Straps sampled once after reset, then frozen
// - Straps 00: one lane per channel
// - Straps 01: ch0-3 lane0, ch4-7 lane1
// - Upper strap high: all channels lane0
// - 24-bit result: header then 16-bit value
// - Strobe and lanes change on clock rise
// - Header: fault, unsettled, repeat, kind, clip, channel
// - Fatal fault sticky until reset
// - Clock lost forces zero values
// - Unsettled set until settle delay elapsed
// - Repeated slot: flag set, zero data
// - Kind bit: 0 wideband, 1 sinc5
// - Pin mode: one filter pin for all
// - Clip at full scale and flag it
// - Per-channel sync delay, default zero
// - Offset field bits and step per decimation
// - Sinc5: first strobe waits smallest offset
// - Delayed sinc5 channel settles one word later
// - All channels wideband: wait for largest offset
// - Strobe low one bit before header
// - Device drives data, clock and strobe
module afpa_framer #(
	parameter BCLK_HALF = `AFPA_BCLK_HALF,
	parameter MOD_DIV = `AFPA_MOD_DIV,
	parameter [5:0] SETTLE_WB = `AFPA_SETTLE_WB,
	parameter [5:0] SETTLE_S5 = `AFPA_SETTLE_S5
) (
	input wire core_clk,
	input wire arst_n,
	input wire lane_layout_strap_lo,
	input wire lane_layout_strap_hi,
	input wire sync_in_n,
	input wire serial_ctrl_mode,
	input wire filter_sel_pin,
	input wire [2:0] dec_sel,
	input wire [7:0] chan_filter_sinc5,
	input wire phase_wr_en,
	input wire [2:0] phase_addr,
	input wire [7:0] phase_wr_data,
	output wire [7:0] phase_rd_data,
	input wire ext_clk_lost,
	input wire cfg_bit_upset,
	input wire crc_mismatch,
	input wire filt_valid,
	input wire [191:0] filt_value,
	input wire [7:0] filt_repeat,
	output reg [7:0] filt_restart_ff,
	output reg bit_shift_clock,
	output reg frame_strobe_n,
	output reg [7:0] serial_result_lane,
	output reg [7:0] serial_result_lane_oe,
	output reg fatal_fault_flag
);
	localparam ST_IDLE = 3'h1;
	localparam ST_STROBE = 3'h2;
	localparam ST_SHIFT = 3'h4;
	localparam NCH = `AFPA_NUM_CH;
	localparam FRAME_BITS = NCH * `AFPA_WORD_BITS;

	// Pin synchronisers: first stage read only by the second
	reg [1:0] strap_lo_sy_ff, strap_hi_sy_ff, mode_sy_ff, fsel_sy_ff;
	reg [2:0] sync_sy_ff;
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_lo_sy_ff <= 2'h0;
			strap_hi_sy_ff <= 2'h0;
			mode_sy_ff <= 2'h0;
			fsel_sy_ff <= 2'h0;
			sync_sy_ff <= 3'h7;
		end else begin
			strap_lo_sy_ff <= {strap_lo_sy_ff[0], lane_layout_strap_lo};
			strap_hi_sy_ff <= {strap_hi_sy_ff[0], lane_layout_strap_hi};
			mode_sy_ff <= {mode_sy_ff[0], serial_ctrl_mode};
			fsel_sy_ff <= {fsel_sy_ff[0], filter_sel_pin};
			sync_sy_ff <= {sync_sy_ff[1:0], sync_in_n};
		end
	end
	// Sync acts on the release edge of the low pulse
	wire sync_rise = sync_sy_ff[1] & ~sync_sy_ff[2];

	// Straps are caught once, after the synchroniser has filled
	reg [1:0] strap_wait_ff;
	reg [1:0] layout_ff;
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_wait_ff <= 2'h0;
			layout_ff <= `AFPA_LAYOUT_8LANE;
		end else if (strap_wait_ff != 2'h3) begin
			strap_wait_ff <= strap_wait_ff + 2'h1;
			if (strap_wait_ff == 2'h2) begin
				if (strap_hi_sy_ff[1]) begin
					layout_ff <= `AFPA_LAYOUT_1LANE;
				end else if (strap_lo_sy_ff[1]) begin
					layout_ff <= `AFPA_LAYOUT_2LANE;
				end else begin
					layout_ff <= `AFPA_LAYOUT_8LANE;
				end
			end
		end
	end
	wire straps_done = (strap_wait_ff == 2'h3);

	// Filter kind per channel
	wire [7:0] kind_sinc5 = mode_sy_ff[1] ? chan_filter_sinc5 : {8{fsel_sy_ff[1]}};
	wire all_wb = (kind_sinc5 == 8'h00);

	// Fatal fault flag holds until reset
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fatal_fault_flag <= 1'b0;
		end else if (ext_clk_lost | cfg_bit_upset | crc_mismatch) begin
			fatal_fault_flag <= 1'b1;
		end
	end

	// Bit clock divider and modulator tick
	reg [7:0] bdiv_ff;
	reg [7:0] mdiv_ff;
	wire bdiv_end = (bdiv_ff == BCLK_HALF[7:0] - 8'h1);
	wire bit_rise = bdiv_end & ~bit_shift_clock;
	wire mod_tick = (mdiv_ff == MOD_DIV[7:0] - 8'h1);
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bdiv_ff <= 8'h00;
			mdiv_ff <= 8'h00;
			bit_shift_clock <= 1'b0;
		end else begin
			bdiv_ff <= bdiv_end ? 8'h00 : bdiv_ff + 8'h01;
			mdiv_ff <= mod_tick ? 8'h00 : mdiv_ff + 8'h01;
			if (bdiv_end) begin
				bit_shift_clock <= ~bit_shift_clock;
			end
		end
	end

	// Phase offsets: scan memory after reset or sync
	reg scan_ff;
	reg boot_ff;
	reg [3:0] scan_idx_ff;
	wire [7:0] mem_rd;
	wire [2:0] mem_raddr = scan_ff ? scan_idx_ff[2:0] : phase_addr;
	assign phase_rd_data = mem_rd;

	afpa_phase_mem #(
		.DEPTH(NCH),
		.AW(3),
		.DW(8)
	) u_mem (
		.clk(core_clk),
		.wr_en(phase_wr_en),
		.wr_addr(phase_addr),
		.wr_data(phase_wr_data),
		.rd_addr(mem_raddr),
		.rd_data(mem_rd)
	);

	// Offset field to modulator periods
	function [9:0] eff_delay;
		input [7:0] ph;
		input [2:0] dec;
		begin
			case (dec)
				`AFPA_DEC_X32: eff_delay = {5'h00, ph[7:3]};
				`AFPA_DEC_X64: eff_delay = {4'h0, ph[7:2]};
				`AFPA_DEC_X128: eff_delay = {3'h0, ph[7:1]};
				`AFPA_DEC_X512: eff_delay = {1'b0, ph, 1'b0};
				`AFPA_DEC_X1024: eff_delay = {ph, 2'h0};
				default: eff_delay = {2'h0, ph};
			endcase
		end
	endfunction

	reg [9:0] dly_ff [0:NCH-1];
	reg run_ff;
	reg [9:0] ph_cnt_ff;
	reg [7:0] armed_ff;
	integer k;
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			scan_ff <= 1'b0;
			boot_ff <= 1'b1;
			scan_idx_ff <= 4'h0;
			run_ff <= 1'b0;
			ph_cnt_ff <= 10'h000;
			for (k = 0; k < NCH; k = k + 1) begin
				dly_ff[k] <= 10'h000;
			end
		end else begin
			boot_ff <= 1'b0;
			if (sync_rise | boot_ff) begin
				scan_ff <= 1'b1;
				scan_idx_ff <= 4'h0;
				run_ff <= 1'b0;
				ph_cnt_ff <= 10'h000;
			end else if (scan_ff) begin
				if (scan_idx_ff != 4'h0) begin
					dly_ff[scan_idx_ff[2:0] - 3'h1] <= eff_delay(mem_rd, dec_sel);
				end
				scan_idx_ff <= scan_idx_ff + 4'h1;
				if (scan_idx_ff == 4'h8) begin
					scan_ff <= 1'b0;
					run_ff <= 1'b1;
				end
			end else if (run_ff) begin
				if (&armed_ff) begin
					run_ff <= 1'b0;
				end else if (mod_tick) begin
					ph_cnt_ff <= ph_cnt_ff + 10'h001;
				end
			end
		end
	end

	// Smallest and largest offset
	reg [9:0] dmin, dmax;
	integer m;
	always @* begin
		dmin = dly_ff[0];
		dmax = dly_ff[0];
		for (m = 1; m < NCH; m = m + 1) begin
			if (dly_ff[m] < dmin) begin
				dmin = dly_ff[m];
			end
			if (dly_ff[m] > dmax) begin
				dmax = dly_ff[m];
			end
		end
	end

	// Frames are held off until the gating channel is ready
	wire gate_open = all_wb ? (&armed_ff) : (|armed_ff);
	reg [2:0] st_ff;
	wire load_any = filt_valid & gate_open & ~scan_ff & straps_done & (st_ff == ST_IDLE);

	// Per-channel arming, restart and settle tracking
	reg [5:0] settle_ff [0:NCH-1];
	wire [FRAME_BITS-1:0] word_w;
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			wire [9:0] thr = all_wb ? dmax : dly_ff[g];
			// Arming only on modulator ticks keeps relative delays whole steps
			wire arm_now = run_ff & mod_tick & ~armed_ff[g] & (ph_cnt_ff >= thr);
			wire [5:0] settle_base = kind_sinc5[g] ? SETTLE_S5 : SETTLE_WB;
			wire late = kind_sinc5[g] & (dly_ff[g] > dmin);
			wire signed [23:0] v = filt_value[24*g +: 24];
			wire clip_hi = (v > $signed({8'h00, `AFPA_POS_FULL}));
			wire clip_lo = (v < $signed({8'hff, `AFPA_NEG_FULL}));
			wire [15:0] clipped = clip_hi ? `AFPA_POS_FULL :
				(clip_lo ? `AFPA_NEG_FULL : v[15:0]);
			wire zero_val = ext_clk_lost | filt_repeat[g];
			wire unsettled = ~armed_ff[g] | (settle_ff[g] != 6'h00);
			wire [7:0] hdr = {fatal_fault_flag | ext_clk_lost, unsettled, filt_repeat[g],
				kind_sinc5[g], clip_hi | clip_lo, g[2:0]};

			always @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					armed_ff[g] <= 1'b0;
					filt_restart_ff[g] <= 1'b0;
					settle_ff[g] <= 6'h00;
				end else begin
					filt_restart_ff[g] <= arm_now;
					if (sync_rise | boot_ff) begin
						armed_ff[g] <= 1'b0;
					end else if (arm_now) begin
						armed_ff[g] <= 1'b1;
						settle_ff[g] <= settle_base + {5'h00, late};
					end else if (load_any & armed_ff[g] & (settle_ff[g] != 6'h00)) begin
						settle_ff[g] <= settle_ff[g] - 6'h01;
					end
				end
			end

			assign word_w[FRAME_BITS-1-24*g -: 24] = {hdr, zero_val ? 16'h0000 : clipped};
		end
	endgenerate

	// Frame engine: strobe, then shift on each bit clock rise
	reg [FRAME_BITS-1:0] sh_ff;
	reg [7:0] cnt_ff;
	reg pend_ff;
	wire [7:0] last_bit = (layout_ff == `AFPA_LAYOUT_8LANE) ? 8'h17 :
		((layout_ff == `AFPA_LAYOUT_2LANE) ? 8'h5f : 8'hbf);
	reg [7:0] taps;
	reg [7:0] oe_w;
	integer t;
	always @* begin
		taps = 8'h00;
		oe_w = 8'h00;
		case (layout_ff)
			`AFPA_LAYOUT_8LANE: begin
				for (t = 0; t < NCH; t = t + 1) begin
					taps[t] = sh_ff[FRAME_BITS-1-24*t];
				end
				oe_w = 8'hff;
			end
			`AFPA_LAYOUT_2LANE: begin
				taps[0] = sh_ff[FRAME_BITS-1];
				taps[1] = sh_ff[FRAME_BITS/2-1];
				oe_w = 8'h03;
			end
			default: begin
				taps[0] = sh_ff[FRAME_BITS-1];
				oe_w = 8'h01;
			end
		endcase
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= ST_IDLE;
			sh_ff <= {FRAME_BITS{1'b0}};
			cnt_ff <= 8'h00;
			pend_ff <= 1'b0;
			frame_strobe_n <= 1'b1;
			serial_result_lane <= 8'h00;
			serial_result_lane_oe <= 8'h00;
		end else begin
			if (straps_done) begin
				serial_result_lane_oe <= oe_w;
			end
			case (st_ff)
				ST_IDLE: begin
					if (load_any) begin
						sh_ff <= word_w;
						pend_ff <= 1'b1;
					end else if (bit_rise & pend_ff) begin
						pend_ff <= 1'b0;
						frame_strobe_n <= 1'b0;
						st_ff <= ST_STROBE;
					end
				end
				ST_STROBE: begin
					if (bit_rise) begin
						frame_strobe_n <= 1'b1;
						serial_result_lane <= taps;
						sh_ff <= {sh_ff[FRAME_BITS-2:0], 1'b0};
						cnt_ff <= last_bit;
						st_ff <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (bit_rise) begin
						if (cnt_ff == 8'h00) begin
							serial_result_lane <= 8'h00;
							st_ff <= ST_IDLE;
						end else begin
							serial_result_lane <= taps;
							sh_ff <= {sh_ff[FRAME_BITS-2:0], 1'b0};
							cnt_ff <= cnt_ff - 8'h01;
						end
					end
				end
				default: begin
					st_ff <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// file: shared/afpa_consts.vh
`ifndef AFPA_CONSTS_VH
`define AFPA_CONSTS_VH

// Strap-selected lane layouts
`define AFPA_LAYOUT_8LANE 2'h0
`define AFPA_LAYOUT_2LANE 2'h1
`define AFPA_LAYOUT_1LANE 2'h2

// Result word: 8-bit header then 16-bit value
`define AFPA_WORD_BITS 24
`define AFPA_DATA_BITS 16
`define AFPA_FILT_BITS 24
`define AFPA_NUM_CH 8

// Header field positions
`define AFPA_HDR_FATAL 7
`define AFPA_HDR_UNSETTLED 6
`define AFPA_HDR_REPEAT 5
`define AFPA_HDR_KIND 4
`define AFPA_HDR_CLIP 3
`define AFPA_HDR_CH_MSB 2

// Clipping limits of the 16-bit two's complement value
`define AFPA_POS_FULL 16'h7fff
`define AFPA_NEG_FULL 16'h8000

// Decimation select codes
`define AFPA_DEC_X32 3'h0
`define AFPA_DEC_X64 3'h1
`define AFPA_DEC_X128 3'h2
`define AFPA_DEC_X256 3'h3
`define AFPA_DEC_X512 3'h4
`define AFPA_DEC_X1024 3'h5

// Timing counts in core clock cycles and in result words
`define AFPA_BCLK_HALF 2
`define AFPA_MOD_DIV 4
`define AFPA_SETTLE_WB 6'h05
`define AFPA_SETTLE_S5 6'h02

`endif

// file: src/afpa_phase_mem.v
`timescale 1ns/1ps
// Eight phase delay words, registered read port.
module afpa_phase_mem #(
	parameter DEPTH = 8,
	parameter AW = 3,
	parameter DW = 8
) (
	input wire clk,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:DEPTH-1];
	integer i;

	// Default contents are zero offsets, so all channels answer sync together
	initial begin
		for (i = 0; i < DEPTH; i = i + 1) begin
			mem[i] = {DW{1'b0}};
		end
		rd_data = {DW{1'b0}};
	end

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// file: bench/afpa_framer_checker.sv
`timescale 1ns/1ps
module afpa_framer_checker #(
	parameter BCLK_HALF = 2
) (
	input wire core_clk,
	input wire arst_n,
	input wire ext_clk_lost,
	input wire cfg_bit_upset,
	input wire crc_mismatch,
	input wire bit_shift_clock,
	input wire frame_strobe_n,
	input wire [7:0] serial_result_lane,
	input wire [7:0] serial_result_lane_oe,
	input wire fatal_fault_flag
);
	wire flt = ext_clk_lost | cfg_bit_upset | crc_mismatch;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_layout_frozen: assert property (
		|$past(serial_result_lane_oe) |-> $stable(serial_result_lane_oe))
		else $error("lane enables changed");
	a_unused_quiet: assert property (
		(serial_result_lane & ~serial_result_lane_oe) == 8'h00)
		else $error("unused lane driven");
	a_rise_aligned: assert property (
		$changed(frame_strobe_n) || $changed(serial_result_lane) |-> $rose(bit_shift_clock))
		else $error("lane moved off clock rise");
	a_bit_clock_half: assert property (
		$changed(bit_shift_clock) |=> $stable(bit_shift_clock) ##(BCLK_HALF-1)
		$changed(bit_shift_clock))
		else $error("bit clock period wrong");
	a_strobe_one_bit: assert property (
		$fell(frame_strobe_n) |-> (!frame_strobe_n)[*4] ##1 frame_strobe_n)
		else $error("strobe not one bit long");
	a_fault_sticky: assert property (fatal_fault_flag |=> fatal_fault_flag)
		else $error("fault flag cleared");
	a_fault_cause: assert property (
		flt |=> fatal_fault_flag) else $error("fault not flagged");
	a_hdr_fault_first: assert property (
		$rose(frame_strobe_n) |-> serial_result_lane[0] == fatal_fault_flag)
		else $error("first header bit wrong");
endmodule

bind afpa_framer afpa_framer_checker #(.BCLK_HALF(BCLK_HALF)) u_afpa_framer_checker (
	.core_clk(core_clk), .arst_n(arst_n), .ext_clk_lost(ext_clk_lost),
	.cfg_bit_upset(cfg_bit_upset), .crc_mismatch(crc_mismatch),
	.bit_shift_clock(bit_shift_clock), .frame_strobe_n(frame_strobe_n),
	.serial_result_lane(serial_result_lane), .serial_result_lane_oe(serial_result_lane_oe),
	.fatal_fault_flag(fatal_fault_flag));

// file: bench/afpa_rx_model.sv
`timescale 1ns/1ps
// Passive receiver; samples mid-bit on the falling clock, away from the launching rise
module afpa_rx_model (
	input wire core_clk,
	input wire bit_shift_clock,
	input wire frame_strobe_n,
	input wire [7:0] serial_result_lane,
	input wire [1:0] lay,
	output reg [191:0] words,
	output reg got
);
	reg bc_ff = 1'b0;
	reg act_ff = 1'b0;
	reg [191:0] sh_ff [0:7];
	integer n = 0;
	integer g;
	integer k;
	initial got = 1'b0;
	always @(posedge core_clk) begin
		bc_ff <= bit_shift_clock;
		got <= 1'b0;
		if (bc_ff && !bit_shift_clock) begin
			if (!frame_strobe_n) begin
				act_ff <= 1'b1;
				n <= 0;
			end else if (act_ff) begin
				for (g = 0; g < 8; g = g + 1)
					sh_ff[g] <= {sh_ff[g][190:0], serial_result_lane[g]};
				n <= n + 1;
				if (n == (lay == 2'h0 ? 23 : lay == 2'h1 ? 95 : 191)) begin
					act_ff <= 1'b0;
					got <= 1'b1;
				end
			end
		end
	end
	always @* begin
		for (k = 0; k < 8; k = k + 1)
			words[24*k+:24] = lay == 2'h0 ? sh_ff[k][23:0] : lay == 2'h1 ?
				sh_ff[k/4][95-24*(k%4)-:24] : sh_ff[0][191-24*k-:24];
	end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
`include "afpa_consts.vh"
module tb_top;
	reg core_clk, arst_n, s_lo, s_hi, sync_n, smode, fpin, wen, elost, upset, crc, fv, flag;
	reg [2:0] dec, paddr;
	reg [7:0] fsel, pdata, rpt;
	reg [191:0] fval;
	reg [63:0] pv;
	reg [1:0] lay;
	reg [31:0] rr;
	wire [7:0] prd, rst8, lanes, oe;
	wire bclk, strobe_n, fault, got;
	wire [191:0] words;
	reg [191:0] exp_q [$];
	integer seed = 17466;
	integer n_mismatch = 0;
	integer check_count = 0;
	integer nacc, i, j, k, t0, t3;
	afpa_framer u_afpa_framer (.core_clk(core_clk), .arst_n(arst_n),
		.lane_layout_strap_lo(s_lo), .lane_layout_strap_hi(s_hi), .sync_in_n(sync_n),
		.serial_ctrl_mode(smode), .filter_sel_pin(fpin), .dec_sel(dec),
		.chan_filter_sinc5(fsel), .phase_wr_en(wen), .phase_addr(paddr),
		.phase_wr_data(pdata), .phase_rd_data(prd), .ext_clk_lost(elost),
		.cfg_bit_upset(upset), .crc_mismatch(crc), .filt_valid(fv), .filt_value(fval),
		.filt_repeat(rpt), .filt_restart_ff(rst8), .bit_shift_clock(bclk),
		.frame_strobe_n(strobe_n), .serial_result_lane(lanes),
		.serial_result_lane_oe(oe), .fatal_fault_flag(fault));
	afpa_rx_model u_afpa_rx_model (.core_clk(core_clk), .bit_shift_clock(bclk),
		.frame_strobe_n(strobe_n), .serial_result_lane(lanes), .lay(lay), .words(words),
		.got(got));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", check_count, n_mismatch);
			if (n_mismatch == 0 && check_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input ok, input string m);
		begin
			check_count = check_count + 1;
			if (ok !== 1'b1) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value at %0t: %0s", $time, m);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge core_clk);
			#1;
		end
	endtask
	task boot(input [1:0] st);
		begin
			{arst_n, s_hi, s_lo, elost, upset, crc, flag, nacc} = {1'b0, st, 4'h0, 32'h0};
			cyc(10);
			arst_n = 1'b1;
			lay = st[1] ? 2'h2 : {1'b0, st[0]};
			cyc(4);
			// Straps flipped after capture must not disturb the layout
			{s_hi, s_lo} = ~st;
			cyc(30);
			chk(oe === (lay == 2'h0 ? 8'hff : lay == 2'h1 ? 8'h03 : 8'h01), "oe");
		end
	endtask
	task send(input calm);
		reg [191:0] e;
		reg [23:0] x;
		reg [31:0] r;
		reg s5, pos, neg, rp;
		integer g;
		begin
			for (g = 0; g < 8; g = g + 1) begin
				r = $random(seed);
				rp = smode & r[25];
				x = (r[24] && !calm && !rp) ? r[23:0] : {{8{r[15]}}, r[15:0]};
				pos = !x[23] && x[22:15] != 8'h00;
				neg = x[23] && x[22:15] != 8'hff;
				s5 = smode ? fsel[g] : fpin;
				fval[24*g+:24] = x;
				rpt[g] = rp;
				e[24*g+:24] = {flag, nacc < (s5 ? `AFPA_SETTLE_S5 : `AFPA_SETTLE_WB), rp, s5,
					pos | neg, g[2:0], (rp || elost) ? 16'h0000 : pos ? 16'h7fff :
					neg ? 16'h8000 : x[15:0]};
			end
			exp_q.push_back(e);
			fv = 1'b1;
			cyc(1);
			fv = 1'b0;
			chk(fault === flag, "fault flag");
			nacc = nacc + 1;
			cyc((24 * (lay == 2'h0 ? 1 : lay == 2'h1 ? 4 : 8) + 3) * 2 * `AFPA_BCLK_HALF);
		end
	endtask
	always @(negedge core_clk) begin
		if (got === 1'b1) begin
			if (exp_q.size() == 0)
				chk(1'b0, "extra frame");
			else
				chk(words === exp_q.pop_front(), "frame");
		end
	end
	initial begin
		{arst_n, s_lo, s_hi, sync_n, smode, fpin, wen, elost, upset, crc, fv} = 11'h080;
		{dec, paddr, fsel, pdata, rpt, fval, lay, flag} = {3'h3, 222'h0};
		for (i = 0; i < 4; i = i + 1) begin
			rr = $random(seed);
			{smode, fpin, fsel} = rr[9:0];
			boot(i[1:0]);
			for (j = 0; j < 7; j = j + 1) begin
				if (j == 4) begin
					flag = 1'b1;
					case (i % 3)
						0: elost = 1'b1;
						1: upset = 1'b1;
						default: crc = 1'b1;
					endcase
					cyc(1);
					{upset, crc} = 2'h0;
				end
				send(j == 4);
				elost = 1'b0;
			end
		end
		pv = {$random(seed), $random(seed)};
		for (k = 0; k < 16; k = k + 1) begin
			{wen, paddr} = {k < 8, k[2:0]};
			pdata = pv[8*k[2:0]+:8];
			cyc(1);
			if (k >= 8)
				chk(prd === pv[8*(k-8)+:8], "phase readback");
		end
		for (k = 0; k < 8; k = k + 1) begin
			{wen, paddr, pdata} = {1'b1, k[2:0], k == 3 ? 8'h08 : 8'h00};
			cyc(1);
		end
		wen = 1'b0;
		smode = 1'b1;
		// Passes 0..5 all sinc5 per decimation, pass 6 all wideband
		for (j = 0; j < 7; j = j + 1) begin
			dec = (j == 6) ? 3'h3 : j[2:0];
			fsel = (j == 6) ? 8'h00 : 8'hff;
			sync_n = 1'b0;
			cyc(3);
			{sync_n, t0, t3} = {1'b1, -32'sd1, -32'sd1};
			for (k = 0; k < 600 && t3 < 0; k = k + 1) begin
				cyc(1);
				if (rst8[0] === 1'b1 && t0 < 0) begin
					t0 = k;
					chk(rst8 === (j == 6 ? 8'hff : 8'hf7), "restart group");
				end
				if (rst8[3] === 1'b1)
					t3 = k;
			end
			chk(t3 - t0 == (j == 6 ? 0 : j < 3 ? 8 >> (3 - j) : 8 << (j - 3)) * `AFPA_MOD_DIV,
				"delay");
			cyc(20);
		end
		chk(exp_q.size() == 0, "missing frame");
		stop_test;
	end
	initial begin
		#300000;
		n_mismatch = n_mismatch + 1;
		stop_test;
	end
endmodule
